// [rtl/tsisw_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tsisw_regs.svh"

// Function
// - in streams 0/4,1/5,2/6,3/7 reach outputs 1-7,3-7,5-7,7 in two channels.
// - channel memories are not initialised; contents undefined until written.
// - reset floats serial outputs and clears registers and frame counters.
// - output gate only floats outputs; never touches registers, memory or counters.
// - top address line low selects control; high selects one of 32 channels.
// - offsets 20-3F are channels 0-31 in the selected memory and stream.
// - control writes answer fast; memory accesses take a longer cycle.
// - split bit: reads from data memory, writes to source memory.
// - stream selector picks the memory subsection in split and normal modes.
// - force bit makes all channels send source memory unless gate low.
// - memory selector 00 reserved, 01 data read-only, 10 source, 11 control.
// - force bit acts as if source and enable bits were one.
// - gate low floats every output; high, each channel's enable bit or the force bit decides.
module tsisw_ctrl
    import tsisw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic [5:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    output logic [7:0] cpuRdData,
    output logic cpuDataOe,
    output logic cpuAck,
    input wire logic masterOutputGate,
    input wire logic [7:0] serialInLines,
    output logic [7:0] serialOutLines,
    output logic [7:0] serialOutEn
);

    localparam int PhaseLast = `TSISW_BIT_CYC - 1;

    // microport state
    tsisw_state_t state_q;
    logic [7:0] ctrl_q;
    tsisw_memsel_t rdSel_q;
    logic [7:0] rdData_q;
    logic dataOe_q;
    logic ack_q;

    // pin synchronisers: three stages, accept when stages two and three agree
    logic [8:0] pinS1_q;
    logic [8:0] pinS2_q;
    logic [8:0] pinS3_q;
    logic [8:0] pinStable_q;

    // serial engine
    logic [4:0] phase_q;
    logic [7:0] bitCnt_q;
    logic [7:0] rxShift_q [8];
    logic [7:0] rxHold_q [8];
    logic [7:0] txShift_q [8];
    logic [7:0] txEn_q;
    logic [7:0] nextByte_q [8];
    logic [7:0] nextEn_q;
    logic [7:0] srcByte_q;
    logic srcForce_q;
    logic srcOe_q;
    logic [7:0] outBits_q;
    logic [7:0] outEn_q;

    // memory ports
    logic [7:0] dmA;
    logic [7:0] dmB;
    logic [7:0] cmlA;
    logic [7:0] cmlB;
    logic [`TSISW_CMH_WIDTH-1:0] cmhA;
    logic [`TSISW_CMH_WIDTH-1:0] cmhB;

    function automatic tsisw_memsel_t memTarget(input logic [7:0] ctrl, input logic wr);
        tsisw_memsel_t sel;
        sel = tsisw_memsel_t'(ctrl[`TSISW_MS_HI:`TSISW_MS_LO]);
        if (ctrl[`TSISW_SPLIT_BIT])
        begin
            sel = wr ? TSISW_MS_SRC : TSISW_MS_DATA;
        end
        else if (wr && sel == TSISW_MS_DATA)
        begin
            sel = TSISW_MS_NONE;
        end
        return sel;
    endfunction

    // microport decode
    wire idle = (state_q == TSISW_IDLE);
    wire take = cpuReq && idle;
    wire chanRegion = cpuAddr[`TSISW_REGION_BIT];
    wire [7:0] cpuMemAddr = {ctrl_q[`TSISW_STA_HI:`TSISW_STA_LO], cpuAddr[4:0]};
    wire tsisw_memsel_t target = memTarget(ctrl_q, cpuWrite);
    wire memWr = take && chanRegion && cpuWrite;
    wire dmWrA = 1'b0; // data memory is read-only from the port
    wire cmlWrA = memWr && (target == TSISW_MS_SRC);
    wire cmhWrA = memWr && (target == TSISW_MS_CTRL);
    wire [7:0] ctrlRead = ctrl_q & `TSISW_CTRL_WMASK;
    wire [7:0] memRead = (rdSel_q == TSISW_MS_DATA) ? dmA :
                         (rdSel_q == TSISW_MS_SRC) ? cmlA :
                         (rdSel_q == TSISW_MS_CTRL) ? {5'h00, cmhA} : 8'h00;

    // serial timing decode
    wire gate = pinStable_q[8];
    wire bitEnd = (phase_q == 5'(PhaseLast));
    wire [2:0] slot = bitCnt_q[2:0];
    wire [4:0] chan = bitCnt_q[7:3];
    wire chanEnd = bitEnd && (slot == `TSISW_LAST_SLOT);
    // input writes land in even slots so outputs after them see fresh data
    wire rxPhase = (phase_q == `TSISW_PH_WR_LO) || (phase_q == `TSISW_PH_WR_HI);
    wire rxWr = rxPhase && !slot[0];
    wire [2:0] rxStream = {phase_q == `TSISW_PH_WR_HI, slot[2:1]};
    wire [7:0] rxAddr = {rxStream, 5'(chan - 5'h01)};
    wire [7:0] fetchAddr = {slot, 5'(chan + 5'h01)};
    wire [7:0] dmBAddr = rxWr ? rxAddr : cmlB;
    wire forceSrc = ctrl_q[`TSISW_FORCE_BIT];
    wire useSrc = forceSrc || srcForce_q;
    wire useOe = forceSrc || srcOe_q;

    tsisw_mem #(.WIDTH(8), .DEPTH(256)) dataMem
    (
        .clk(clk),
        .aWrite(dmWrA),
        .aAddr(cpuMemAddr),
        .aWrData(cpuWrData),
        .aRdData(dmA),
        .bWrite(rxWr),
        .bAddr(dmBAddr),
        .bWrData(rxHold_q[rxStream]),
        .bRdData(dmB)
    );

    // no reset on either channel memory; software must fill it
    tsisw_mem #(.WIDTH(8), .DEPTH(256)) srcMem
    (
        .clk(clk),
        .aWrite(cmlWrA),
        .aAddr(cpuMemAddr),
        .aWrData(cpuWrData),
        .aRdData(cmlA),
        .bWrite(1'b0),
        .bAddr(fetchAddr),
        .bWrData(8'h00),
        .bRdData(cmlB)
    );

    tsisw_mem #(.WIDTH(`TSISW_CMH_WIDTH), .DEPTH(256)) chanCtrlMem
    (
        .clk(clk),
        .aWrite(cmhWrA),
        .aAddr(cpuMemAddr),
        .aWrData(cpuWrData[`TSISW_CMH_WIDTH-1:0]),
        .aRdData(cmhA),
        .bWrite(1'b0),
        .bAddr(fetchAddr),
        .bWrData(3'h0),
        .bRdData(cmhB)
    );

    // microport: control write acks next cycle, memory one cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= TSISW_IDLE;
            ctrl_q <= `TSISW_CTRL_RESET;
            rdSel_q <= TSISW_MS_NONE;
            rdData_q <= 8'h00;
            dataOe_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= 1'b0;
            dataOe_q <= 1'b0;
            state_q <= TSISW_IDLE;
            if (take && !chanRegion)
            begin
                ack_q <= 1'b1;
                dataOe_q <= !cpuWrite;
                rdData_q <= ctrlRead;
                if (cpuWrite)
                begin
                    ctrl_q <= cpuWrData & `TSISW_CTRL_WMASK;
                end
            end
            else if (take)
            begin
                state_q <= TSISW_MEM;
                rdSel_q <= target;
            end
            else if (state_q == TSISW_MEM)
            begin
                ack_q <= 1'b1;
                dataOe_q <= !cpuWrite;
                rdData_q <= memRead;
            end
        end
    end

    // gate pin is synchronised but feeds nothing except the output enables
    always_ff @(posedge clk)
    begin
        pinS1_q <= {masterOutputGate, serialInLines};
        pinS2_q <= pinS1_q;
        pinS3_q <= pinS2_q;
        for (int i = 0; i < 9; i++)
        begin
            if (pinS2_q[i] == pinS3_q[i])
            begin
                pinStable_q[i] <= pinS3_q[i];
            end
        end
    end

    // frame counters
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            phase_q <= 5'h00;
            bitCnt_q <= 8'h00;
        end
        else
        begin
            phase_q <= bitEnd ? 5'h00 : 5'(phase_q + 5'h01);
            if (bitEnd)
            begin
                bitCnt_q <= 8'(bitCnt_q + 8'h01);
            end
        end
    end

    // fetch for the next channel, one stream per bit slot
    always_ff @(posedge clk)
    begin
        if (phase_q == `TSISW_PH_SRC)
        begin
            srcForce_q <= cmhB[`TSISW_CMH_SRC_BIT];
            srcOe_q <= cmhB[`TSISW_CMH_OE_BIT];
            srcByte_q <= cmlB;
        end
        if (phase_q == `TSISW_PH_DATA)
        begin
            nextByte_q[slot] <= useSrc ? srcByte_q : dmB;
            nextEn_q[slot] <= useOe;
        end
    end

    // receive and transmit shifters, msb first
    always_ff @(posedge clk)
    begin
        for (int s = 0; s < 8; s++)
        begin
            if (phase_q == `TSISW_PH_SAMPLE)
            begin
                rxShift_q[s] <= {rxShift_q[s][6:0], pinStable_q[s]};
            end
            if (chanEnd)
            begin
                rxHold_q[s] <= rxShift_q[s];
                txShift_q[s] <= nextByte_q[s];
            end
            else if (bitEnd)
            begin
                txShift_q[s] <= {txShift_q[s][6:0], 1'b0};
            end
        end
    end

    // outputs float in reset and while the gate is low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txEn_q <= 8'h00;
            outBits_q <= 8'h00;
            outEn_q <= 8'h00;
        end
        else
        begin
            if (chanEnd)
            begin
                txEn_q <= nextEn_q;
            end
            for (int s = 0; s < 8; s++)
            begin
                outBits_q[s] <= txShift_q[s][7];
            end
            outEn_q <= gate ? txEn_q : 8'h00;
        end
    end

    assign cpuRdData = rdData_q;
    assign cpuDataOe = dataOe_q;
    assign cpuAck = ack_q;
    assign serialOutLines = outBits_q;
    assign serialOutEn = outEn_q;

endmodule

`default_nettype wire

// [pkg/tsisw_regs.svh]
`ifndef TSISW_REGS_SVH
`define TSISW_REGS_SVH

// microport address map
`define TSISW_REGION_BIT 5
`define TSISW_CTRL_OFS 6'h00
`define TSISW_CHAN_OFS 6'h20

// control register fields
`define TSISW_SPLIT_BIT 7
`define TSISW_FORCE_BIT 6
`define TSISW_UNUSED_BIT 5
`define TSISW_MS_HI 4
`define TSISW_MS_LO 3
`define TSISW_STA_HI 2
`define TSISW_STA_LO 0
`define TSISW_CTRL_RESET 8'h00
`define TSISW_CTRL_WMASK 8'hDF

// per-channel control memory bits
`define TSISW_CMH_SRC_BIT 2
`define TSISW_CMH_CCO_BIT 1
`define TSISW_CMH_OE_BIT 0
`define TSISW_CMH_WIDTH 3

// serial timing: 2.048 Mb/s bit period on a 20 ns clock
`define TSISW_BIT_NS 488
`define TSISW_CLK_NS 20
`define TSISW_BIT_CYC (`TSISW_BIT_NS / `TSISW_CLK_NS)
`define TSISW_PH_FETCH 5'h00
`define TSISW_PH_SRC 5'h01
`define TSISW_PH_DATA 5'h02
`define TSISW_PH_WR_LO 5'h04
`define TSISW_PH_WR_HI 5'h06
`define TSISW_PH_SAMPLE 5'h0C
`define TSISW_LAST_SLOT 3'h7

`endif

// [pkg/tsisw_pkg.sv]
`default_nettype none
package tsisw_pkg;

    typedef enum logic
    {
        TSISW_IDLE = 1'b0,
        TSISW_MEM = 1'b1
    } tsisw_state_t;

    typedef enum logic [1:0]
    {
        TSISW_MS_NONE = 2'h0,
        TSISW_MS_DATA = 2'h1,
        TSISW_MS_SRC = 2'h2,
        TSISW_MS_CTRL = 2'h3
    } tsisw_memsel_t;

endpackage

`default_nettype wire

// [rtl/tsisw_mem.sv]
`timescale 1ns/1ns
`default_nettype none

// two-port ram, registered read data on both ports; contents are never reset
module tsisw_mem
    import tsisw_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256
)
(
    input wire logic clk,
    input wire logic aWrite,
    input wire logic [7:0] aAddr,
    input wire logic [WIDTH-1:0] aWrData,
    output logic [WIDTH-1:0] aRdData,
    input wire logic bWrite,
    input wire logic [7:0] bAddr,
    input wire logic [WIDTH-1:0] bWrData,
    output logic [WIDTH-1:0] bRdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (aWrite)
        begin
            mem[aAddr] <= aWrData;
        end
        if (bWrite)
        begin
            mem[bAddr] <= bWrData;
        end
        aRdData <= mem[aAddr];
        bRdData <= mem[bAddr];
    end

endmodule

`default_nettype wire

// [testbench/tsisw_ctrl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module tsisw_ctrl_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic [5:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    input wire logic [7:0] cpuRdData,
    input wire logic cpuDataOe,
    input wire logic cpuAck,
    input wire logic masterOutputGate,
    input wire logic [7:0] serialInLines,
    input wire logic [7:0] serialOutLines,
    input wire logic [7:0] serialOutEn
);
    logic pendQ;
    logic [7:0] ctrlQ;
    logic [9:0] forceCntQ;
    // a request in the cycle after a memory request is dropped
    wire logic ctrlTake = cpuReq && !pendQ && !cpuAddr[5];
    wire logic memTake = cpuReq && !pendQ && cpuAddr[5];
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pendQ <= 1'b0;
            ctrlQ <= 8'h00;
            forceCntQ <= 10'h000;
        end
        else
        begin
            pendQ <= memTake;
            if (ctrlTake && cpuWrite)
                ctrlQ <= cpuWrData & 8'hDF;
            if (!ctrlQ[6] || !masterOutputGate)
                forceCntQ <= 10'h000;
            else if (forceCntQ != 10'h3FF)
                forceCntQ <= forceCntQ + 10'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ctrl_ack_a: assert property (ctrlTake |=> cpuAck)
        else $error("control access not acked next cycle");
    mem_ack_a: assert property (memTake |=> !cpuAck ##1 cpuAck)
        else $error("memory access not acked two cycles later");
    ack_cause_a: assert property (cpuAck |-> $past(ctrlTake) || $past(memTake, 2))
        else $error("ack without a matching request");
    ctrl_read_a: assert property (ctrlTake && !cpuWrite |=> cpuDataOe && cpuRdData == ctrlQ)
        else $error("control read value wrong");
    reserved_read_a: assert property (memTake && !cpuWrite && !ctrlQ[7] && ctrlQ[4:3] == 2'h0
        |-> ##2 cpuDataOe && cpuRdData == 8'h00)
        else $error("reserved selector read not zero");
    write_quiet_a: assert property ((ctrlTake || memTake) && cpuWrite |-> ##[1:2] !cpuDataOe)
        else $error("data bus driven on a write");
    reset_float_a: assert property ($fell(rst) |-> serialOutEn == 8'h00 && cpuRdData == 8'h00)
        else $error("outputs not reset");
    gate_float_a: assert property (!masterOutputGate [*8] |-> serialOutEn == 8'h00)
        else $error("output driven while gate low");
    force_drive_a: assert property (forceCntQ >= 10'h1C2 |-> serialOutEn == 8'hFF)
        else $error("forced source not driving all streams");
endmodule
bind tsisw_ctrl tsisw_ctrl_checker chk
(
    .clk(clk), .rst(rst), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
    .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuDataOe(cpuDataOe), .cpuAck(cpuAck),
    .masterOutputGate(masterOutputGate), .serialInLines(serialInLines),
    .serialOutLines(serialOutLines), .serialOutEn(serialOutEn)
);
`default_nettype wire

// [testbench/tsisw_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module tsisw_cpu_model
(
    input wire logic clk,
    input wire logic cpuAck,
    input wire logic cpuDataOe,
    input wire logic [7:0] cpuRdData,
    output logic cpuReq,
    output logic cpuWrite,
    output logic [5:0] cpuAddr,
    output logic [7:0] cpuWrData,
    output logic masterOutputGate
);
    initial
    begin
        cpuReq = 1'b0;
        cpuWrite = 1'b0;
        cpuAddr = 6'h00;
        cpuWrData = 8'h00;
        masterOutputGate = 1'b0;
    end
    // memory cycles are slower, so always wait on ack
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        q = 8'h00;
        @(negedge clk);
        cpuReq = 1'b1;
        cpuWrite = w;
        cpuAddr = a;
        cpuWrData = d;
        @(negedge clk);
        cpuReq = 1'b0;
        while (cpuAck !== 1'b1 && n < 6)
        begin
            @(negedge clk);
            n++;
        end
        ok = (cpuAck === 1'b1);
        if (cpuDataOe === 1'b1)
            q = cpuRdData;
        // released bus must not show a stale value
        cpuWrite = ~w;
        cpuAddr = ~a;
        cpuWrData = ~d;
    endtask
    task automatic gate(input logic g);
        @(negedge clk);
        masterOutputGate = g;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_tsi_switch_cpu_control.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end
module tb_tsi_switch_cpu_control;
    logic clk;
    logic rst;
    logic cpuReq;
    logic cpuWrite;
    logic [5:0] cpuAddr;
    logic [7:0] cpuWrData;
    logic [7:0] cpuRdData;
    logic cpuDataOe;
    logic cpuAck;
    logic masterOutputGate;
    logic [7:0] serialInLines;
    logic [7:0] serialOutEn;
    logic [7:0] serialOutLines;
    int sinceRst = 0;
    logic [7:0] rd;
    logic ok;
    int miscompares = 0;
    int checksDone = 0;
    // {write, offset, data, expected read}
    logic [27:0] rows [23] = '{
        28'h1_00_13_00, 28'h1_25_A5_00, 28'h1_00_1B_00, 28'h1_25_FF_00, 28'h0_25_00_07,
        28'h1_00_13_00, 28'h0_25_00_A5, 28'h1_00_14_00, 28'h1_25_3C_00, 28'h1_00_13_00,
        28'h0_25_00_A5, 28'h1_00_0B_00, 28'h1_25_00_00, 28'h0_25_00_FF, 28'h1_00_83_00,
        28'h0_25_00_FF, 28'h1_25_5A_00, 28'h1_00_13_00, 28'h0_25_00_5A, 28'h1_00_FF_00,
        28'h0_1F_00_DF, 28'h1_00_00_00, 28'h0_3F_00_00};
    tsisw_ctrl DUT
    (
        .clk(clk), .rst(rst), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
        .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuDataOe(cpuDataOe), .cpuAck(cpuAck),
        .masterOutputGate(masterOutputGate), .serialInLines(serialInLines),
        .serialOutLines(serialOutLines), .serialOutEn(serialOutEn)
    );
    tsisw_cpu_model cpu
    (
        .clk(clk), .cpuAck(cpuAck), .cpuDataOe(cpuDataOe), .cpuRdData(cpuRdData),
        .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
        .masterOutputGate(masterOutputGate)
    );
    task automatic final_report();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // edges since reset release: 24 per bit, 8 bits per channel
    always @(posedge clk)
    begin
        sinceRst <= rst ? 0 : sinceRst + 1;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial
    begin
        rst = 1'b1;
        // steady ones fill data memory just over one frame after reset: channel 31 lands in channel 0 of the next frame
        serialInLines = 8'hFF;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (6300) @(negedge clk);
        for (int i = 0; i < 23; i++)
        begin
            cpu.access(rows[i][24], rows[i][21:16], rows[i][15:8], rd, ok);
            `CHECK(ok, 1'b1)
            if (rows[i][24] == 1'b0)
                `CHECK(rd, rows[i][7:0])
        end
        // forced source drives every channel, so no two outputs share a line here
        cpu.access(1'b1, 6'h00, 8'h40, rd, ok);
        cpu.gate(1'b1);
        repeat (500) @(negedge clk);
        `CHECK(serialOutEn, 8'hFF)
        cpu.gate(1'b0);
        repeat (8) @(negedge clk);
        `CHECK(serialOutEn, 8'h00)
        cpu.access(1'b0, 6'h00, 8'h00, rd, ok);
        `CHECK(rd, 8'h40)
        cpu.gate(1'b1);
        repeat (10) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHECK(serialOutEn, 8'h00)
        rst = 1'b0;
        cpu.access(1'b0, 6'h00, 8'h00, rd, ok);
        `CHECK(rd, 8'h00)
        // stream 3: ch5 sends source byte, ch6 floats, ch7 relays data memory (all ones)
        cpu.access(1'b1, 6'h00, 8'h13, rd, ok);
        cpu.access(1'b1, 6'h27, 8'h2A, rd, ok);
        cpu.access(1'b1, 6'h00, 8'h1B, rd, ok);
        cpu.access(1'b1, 6'h26, 8'h00, rd, ok);
        cpu.access(1'b1, 6'h27, 8'h01, rd, ok);
        for (int j = 0; j < 8; j++)
        begin
            while (sinceRst != 24 * (40 + j) + 12)
                @(negedge clk);
            // row 16 left 5A in source memory at stream 3 channel 5
            `CHECK(serialOutLines[3], rows[16][15 - j])
            `CHECK(serialOutEn[3], 1'b1)
        end
        while (sinceRst != 24 * 48 + 12)
            @(negedge clk);
        `CHECK(serialOutEn[3], 1'b0)
        for (int j = 0; j < 8; j++)
        begin
            while (sinceRst != 24 * (56 + j) + 12)
                @(negedge clk);
            `CHECK(serialOutLines[3], 1'b1)
            `CHECK(serialOutEn[3], 1'b1)
        end
        final_report();
    end
endmodule
`default_nettype wire
